//--- core/pmcm_periph_gate.sv
// Per-peripheral clock enables, held off from the cycle after the system clock stops
`timescale 1ns/1ps
`default_nettype none
module pmcm_periph_gate (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_sys_on,
    input wire logic [pmcm_pkg::NUM_PERIPH-1:0] i_enable,
    output logic [pmcm_pkg::NUM_PERIPH-1:0] o_clk_en
);
    import pmcm_pkg::*;

    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g++) begin : g_gate
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    o_clk_en[g] <= GATE_RST[g];
                end else begin
                    o_clk_en[g] <= i_sys_on & i_enable[g];
                end
            end
        end
    endgenerate

    property p_gate_off_sys_stop;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_sys_on |=> o_clk_en == '0;
    endproperty
    a_gate_off_sys_stop: assert property (p_gate_off_sys_stop)
        else $error("peripheral clock runs while system clock stopped");

    property p_gate_follows;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_sys_on && $stable(i_sys_on) && $stable(i_enable)
            |-> o_clk_en == i_enable;
    endproperty
    a_gate_follows: assert property (p_gate_follows)
        else $error("peripheral clock enable does not follow its bit");
endmodule
`default_nettype wire

//--- core/pmcm_pkg.sv
// Shared constants, register map and state codes of the power mode manager
package pmcm_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int VSTEP_NS = 10000;
    localparam int VSTEP_CYC = (VSTEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VCNT_W = 9;
    localparam int NUM_PERIPH = 16;
    localparam int MULT_W = 6;
    localparam int VOLT_W = 4;
    localparam int ADR_W = 8;

    localparam logic [ADR_W-1:0] ADR_MODE = 8'h00;
    localparam logic [ADR_W-1:0] ADR_MULT = 8'h04;
    localparam logic [ADR_W-1:0] ADR_VOLT = 8'h08;
    localparam logic [ADR_W-1:0] ADR_GATE = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_STAT = 8'h10;

    localparam int MODE_REQ_LSB = 0;
    localparam int MODE_PLLOFF_BIT = 4;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MULT_LSB = 8;
    localparam int STAT_PLL_BIT = 16;
    localparam int STAT_BYP_BIT = 17;
    localparam int STAT_CORE_CLOCK_BIT = 18;
    localparam int STAT_SCLK_BIT = 19;
    localparam int STAT_PWR_BIT = 20;
    localparam int STAT_DMA_BIT = 21;
    localparam int STAT_VLVL_LSB = 24;

    localparam logic [MULT_W-1:0] MULT_RST = 6'h0A;
    localparam logic [VOLT_W-1:0] VOLT_RST = 4'hC;
    localparam logic [NUM_PERIPH-1:0] GATE_RST = 16'hFFFF;

    typedef enum logic [2:0] {
        PM_FULL_ON = 3'b000,
        PM_ACTIVE = 3'b001,
        PM_SLEEP = 3'b010,
        PM_DEEP = 3'b011,
        PM_HIBERN = 3'b100
    } pmcm_state_e;
endpackage

//--- core/pmcm_top.sv
// Power mode manager: operating states, clock and power controls, registers
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmcm_top (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [pmcm_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_wakeup,
    output logic o_pll_en,
    output logic o_pll_bypass,
    output logic o_core_clk_en,
    output logic o_sys_clk_en,
    output logic o_core_pwr_on,
    output logic o_dma_l1_avail,
    output logic [pmcm_pkg::MULT_W-1:0] o_core_mult,
    output logic [pmcm_pkg::NUM_PERIPH-1:0] o_periph_clk_en,
    output logic [pmcm_pkg::VOLT_W-1:0] o_vcore_level
);
    import pmcm_pkg::*;

    pmcm_state_e state_q;
    pmcm_state_e state_d;
    pmcm_state_e run_mode_q;
    logic [2:0] mode_req_q;
    logic pll_off_act_q;
    logic [MULT_W-1:0] mult_pend_q;
    logic [MULT_W-1:0] mult_app_q;
    logic [VOLT_W-1:0] volt_sel_q;
    logic [NUM_PERIPH-1:0] gate_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic bus_go;
    logic wr_go;
    logic mode_wr;
    logic mode_ok;

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_core_mult = mult_app_q;

    // Bus request is taken once, on the edge that raises ack
    assign bus_go = i_wb_cyc & i_wb_stb & ~ack_q;
    assign wr_go = bus_go & i_wb_we;
    assign mode_wr = wr_go & i_wb_sel[0] & (i_wb_adr == ADR_MODE);
    assign mode_ok = i_wb_dat[MODE_REQ_LSB +: 3] <= 3'(PM_DEEP);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_go;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mode_req_q <= 3'(PM_FULL_ON);
            pll_off_act_q <= 1'b0;
        end else if (mode_wr) begin
            mode_req_q <= i_wb_dat[MODE_REQ_LSB +: 3];
            pll_off_act_q <= i_wb_dat[MODE_PLLOFF_BIT];
        end
    end

    // Ratio may be written in any state; it reaches the loop only on entry
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mult_pend_q <= MULT_RST;
        end else if (wr_go && i_wb_sel[0] && i_wb_adr == ADR_MULT) begin
            mult_pend_q <= i_wb_dat[MULT_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mult_app_q <= MULT_RST;
        end else if (state_d == PM_FULL_ON && state_q != PM_FULL_ON) begin
            mult_app_q <= mult_pend_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            volt_sel_q <= VOLT_RST;
        end else if (wr_go && i_wb_sel[0] && i_wb_adr == ADR_VOLT) begin
            volt_sel_q <= i_wb_dat[VOLT_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gate_q <= GATE_RST;
        end else if (wr_go && i_wb_adr == ADR_GATE) begin
            if (i_wb_sel[0]) begin
                gate_q[7:0] <= i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                gate_q[15:8] <= i_wb_dat[15:8];
            end
        end
    end

    // Zero supply outranks any mode request; wake returns to last run mode
    always_comb begin
        state_d = state_q;
        if (volt_sel_q == '0) begin
            state_d = PM_HIBERN;
        end else if (state_q == PM_HIBERN) begin
            state_d = PM_FULL_ON;
        end else if (mode_wr && mode_ok) begin
            state_d = pmcm_state_e'(i_wb_dat[MODE_REQ_LSB +: 3]);
        end else if (i_wakeup &&
                     (state_q == PM_SLEEP || state_q == PM_DEEP)) begin
            state_d = run_mode_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= PM_FULL_ON;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            run_mode_q <= PM_FULL_ON;
        end else if (state_d == PM_FULL_ON || state_d == PM_ACTIVE) begin
            run_mode_q <= state_d;
        end
    end

    // Controls are registered from the next state so they line up with it
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pll_en <= 1'b1;
            o_pll_bypass <= 1'b0;
            o_core_clk_en <= 1'b1;
            o_sys_clk_en <= 1'b1;
            o_core_pwr_on <= 1'b1;
            o_dma_l1_avail <= 1'b1;
        end else begin
            case (state_d)
                PM_FULL_ON: begin
                    o_pll_en <= 1'b1;
                    o_pll_bypass <= 1'b0;
                    o_core_clk_en <= 1'b1;
                    o_sys_clk_en <= 1'b1;
                    o_core_pwr_on <= 1'b1;
                    o_dma_l1_avail <= 1'b1;
                end
                PM_ACTIVE: begin
                    o_pll_en <= ~pll_off_act_q;
                    o_pll_bypass <= 1'b1;
                    o_core_clk_en <= 1'b1;
                    o_sys_clk_en <= 1'b1;
                    o_core_pwr_on <= 1'b1;
                    o_dma_l1_avail <= 1'b1;
                end
                PM_SLEEP: begin
                    o_pll_en <= 1'b1;
                    o_pll_bypass <= 1'b0;
                    o_core_clk_en <= 1'b0;
                    o_sys_clk_en <= 1'b1;
                    o_core_pwr_on <= 1'b1;
                    o_dma_l1_avail <= 1'b0;
                end
                PM_DEEP: begin
                    o_pll_en <= 1'b0;
                    o_pll_bypass <= 1'b0;
                    o_core_clk_en <= 1'b0;
                    o_sys_clk_en <= 1'b0;
                    o_core_pwr_on <= 1'b1;
                    o_dma_l1_avail <= 1'b0;
                end
                default: begin
                    o_pll_en <= 1'b0;
                    o_pll_bypass <= 1'b0;
                    o_core_clk_en <= 1'b0;
                    o_sys_clk_en <= 1'b0;
                    o_core_pwr_on <= 1'b0;
                    o_dma_l1_avail <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rdat_d = '0;
        case (i_wb_adr)
            ADR_MODE: begin
                rdat_d[MODE_REQ_LSB +: 3] = mode_req_q;
                rdat_d[MODE_PLLOFF_BIT] = pll_off_act_q;
            end
            ADR_MULT: begin
                rdat_d[MULT_W-1:0] = mult_pend_q;
            end
            ADR_VOLT: begin
                rdat_d[VOLT_W-1:0] = volt_sel_q;
            end
            ADR_GATE: begin
                rdat_d[NUM_PERIPH-1:0] = gate_q;
            end
            ADR_STAT: begin
                rdat_d[STAT_STATE_LSB +: 3] = state_q;
                rdat_d[STAT_MULT_LSB +: MULT_W] = mult_app_q;
                rdat_d[STAT_PLL_BIT] = o_pll_en;
                rdat_d[STAT_BYP_BIT] = o_pll_bypass;
                rdat_d[STAT_CORE_CLOCK_BIT] = o_core_clk_en;
                rdat_d[STAT_SCLK_BIT] = o_sys_clk_en;
                rdat_d[STAT_PWR_BIT] = o_core_pwr_on;
                rdat_d[STAT_DMA_BIT] = o_dma_l1_avail;
                rdat_d[STAT_VLVL_LSB +: VOLT_W] = o_vcore_level;
            end
            default: begin
                rdat_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdat_q <= '0;
        end else if (bus_go && !i_wb_we) begin
            rdat_q <= rdat_d;
        end
    end

    pmcm_periph_gate u_gate (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_sys_on(o_sys_clk_en),
        .i_enable(gate_q),
        .o_clk_en(o_periph_clk_en)
    );

    pmcm_volt_ctl u_volt (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_target(volt_sel_q),
        .o_level(o_vcore_level)
    );

    property p_reset_full_on;
        @(posedge i_sys_clk)
        i_rst |=> state_q == PM_FULL_ON && o_core_clk_en && !o_pll_bypass;
    endproperty
    a_reset_full_on: assert property (p_reset_full_on)
        else $error("reset did not land in full-on");

    property p_full_on_ctrl;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_FULL_ON |-> o_pll_en && !o_pll_bypass &&
            o_core_clk_en && o_sys_clk_en && o_core_pwr_on;
    endproperty
    a_full_on_ctrl: assert property (p_full_on_ctrl)
        else $error("full-on controls wrong");

    property p_active_ctrl;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_ACTIVE |-> o_pll_bypass && o_core_clk_en &&
            o_sys_clk_en && o_core_pwr_on;
    endproperty
    a_active_ctrl: assert property (p_active_ctrl)
        else $error("active controls wrong");

    property p_ratio_held;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q != PM_FULL_ON ##1 state_q != PM_FULL_ON
            |-> $stable(o_core_mult);
    endproperty
    a_ratio_held: assert property (p_ratio_held)
        else $error("ratio changed outside full-on entry");

    property p_ratio_applied;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q != PM_FULL_ON ##1 state_q == PM_FULL_ON
            |-> o_core_mult == $past(mult_pend_q);
    endproperty
    a_ratio_applied: assert property (p_ratio_applied)
        else $error("pending ratio not applied on full-on entry");

    property p_dma_avail;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_ACTIVE |-> o_dma_l1_avail;
    endproperty
    a_dma_avail: assert property (p_dma_avail)
        else $error("memory DMA unavailable in active");

    property p_sleep_ctrl;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_SLEEP |-> !o_core_clk_en && o_sys_clk_en &&
            o_pll_en && o_core_pwr_on;
    endproperty
    a_sleep_ctrl: assert property (p_sleep_ctrl)
        else $error("sleep controls wrong");

    property p_zero_volt_hib;
        @(posedge i_sys_clk) disable iff (i_rst)
        volt_sel_q == '0 |=> state_q == PM_HIBERN;
    endproperty
    a_zero_volt_hib: assert property (p_zero_volt_hib)
        else $error("zero supply setting did not hibernate");

    property p_hib_ctrl;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_HIBERN |-> !o_pll_en && !o_core_clk_en &&
            !o_sys_clk_en && !o_core_pwr_on;
    endproperty
    a_hib_ctrl: assert property (p_hib_ctrl)
        else $error("hibernate controls wrong");

    property p_deep_ctrl;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_q == PM_DEEP |-> !o_pll_en && !o_core_clk_en &&
            !o_sys_clk_en && o_core_pwr_on;
    endproperty
    a_deep_ctrl: assert property (p_deep_ctrl)
        else $error("deep sleep controls wrong");
endmodule
`default_nettype wire

//--- core/pmcm_volt_ctl.sv
// Core supply level that walks one step at a time toward the set value
`timescale 1ns/1ps
`default_nettype none
module pmcm_volt_ctl (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [pmcm_pkg::VOLT_W-1:0] i_target,
    output logic [pmcm_pkg::VOLT_W-1:0] o_level
);
    import pmcm_pkg::*;

    localparam int STEP_WAIT = 401;
    logic [VCNT_W-1:0] cnt_q;

    // One step per dwell keeps regulator slew bounded
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            o_level <= VOLT_RST;
        end else if (o_level == i_target) begin
            cnt_q <= '0;
        end else if (cnt_q == VCNT_W'(VSTEP_CYC - 1)) begin
            cnt_q <= '0;
            if (o_level < i_target) begin
                o_level <= o_level + 4'h1;
            end else begin
                o_level <= o_level - 4'h1;
            end
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    property p_level_moves;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_level != i_target
            |-> ##[1:STEP_WAIT] ($changed(o_level) || o_level == i_target);
    endproperty
    a_level_moves: assert property (p_level_moves)
        else $error("core supply level stuck away from its setting");
endmodule
`default_nettype wire

//--- testbench/pmcm_top_tb.sv
// Self-checking bench of the power mode manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end \
end
module pmcm_top_tb;
    import pmcm_pkg::*;
    logic clk, rst, cyc, stb, we, wake, ack, pll, byp, cen, sen, pwr, dma;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel, lanes;
    logic [31:0] wdat, rdat, rd, r;
    logic [MULT_W-1:0] mult, pend, appl;
    logic [NUM_PERIPH-1:0] pclk;
    logic [VOLT_W-1:0] lvl;
    logic [2:0] s, run;
    logic [5:0] c, seen;
    logic [27:0] exp_st;
    logic pl_off;
    int bad_count, checks, n;

    pmcm_top pmcm_top_inst (
        .i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_wakeup(wake),
        .o_pll_en(pll), .o_pll_bypass(byp), .o_core_clk_en(cen),
        .o_sys_clk_en(sen), .o_core_pwr_on(pwr), .o_dma_l1_avail(dma),
        .o_core_mult(mult), .o_periph_clk_en(pclk), .o_vcore_level(lvl)
    );

    // Bit order: dma, power, system clock, core clock, bypass, loop
    function automatic logic [5:0] ctl_of(input logic [2:0] st,
                                          input logic p);
        case (st)
            3'h0: ctl_of = 6'h3D;
            3'h1: ctl_of = {5'h1F, ~p};
            3'h2: ctl_of = 6'h19;
            3'h3: ctl_of = 6'h10;
            default: ctl_of = 6'h00;
        endcase
    endfunction

    task automatic finish_test();
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Classic single cycle; the answer is awaited, never assumed
    task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        `CHK("ack", 1'b1, ack)
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        #1;
    endtask

    task automatic check_all();
        c = ctl_of(s, pl_off);
        seen = {dma, pwr, sen, cen, byp, pll};
        `CHK("controls", c, seen)
        `CHK("ratio", appl, mult)
        wb(1'b0, ADR_STAT, 32'h0);
        // Level field left out: it may step at any moment while walking
        exp_st = {6'h00, c, 2'h0, appl, 5'h00, s};
        `CHK("status", exp_st, {rd[31:28], rd[23:0]})
    endtask

    task automatic set_mode(input logic [4:0] m);
        wb(1'b1, ADR_MODE, {27'h0, m});
        if (m[2:0] <= 3'h3 && s != 3'h4) begin
            if (m[2:0] == 3'h0 && s != 3'h0) begin
                appl = pend;
            end
            s = m[2:0];
            pl_off = m[4];
            if (s <= 3'h1) begin
                run = s;
            end
        end
    endtask

    task automatic wake_up();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        if (s == 3'h2 || s == 3'h3) begin
            if (run == 3'h0) begin
                appl = pend;
            end
            s = run;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        {cyc, stb, we, wake} = 4'h0;
        adr = '0;
        sel = '0;
        wdat = '0;
        lanes = 4'hF;
        bad_count = 0;
        checks = 0;
        s = 3'h0;
        run = 3'h0;
        pl_off = 1'b0;
        pend = MULT_RST;
        appl = MULT_RST;
        void'($urandom(27));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("gates", GATE_RST, pclk)
        `CHK("level", VOLT_RST, lvl)
        check_all();
        for (n = 0; n < 30; n++) begin
            r = $urandom;
            if (r[5]) begin
                pend = r[13:8];
                wb(1'b1, ADR_MULT, {26'h0, pend});
            end
            // Refused mode codes keep the loop-off bit so it cannot matter
            set_mode({(r[2:0] > 3'h3) ? pl_off : r[4], 1'b0, r[2:0]});
            if (r[6]) begin
                wake_up();
            end
            check_all();
            c = ctl_of(s, pl_off);
            wb(1'b1, ADR_GATE, {16'h0, r[31:16]});
            `CHK("gates", r[31:16] & {NUM_PERIPH{c[3]}}, pclk)
        end
        set_mode(5'h00);
        wb(1'b1, ADR_GATE, 32'h0);
        lanes = 4'h2;
        wb(1'b1, ADR_GATE, 32'h0000ABCD);
        lanes = 4'hF;
        `CHK("lane gates", 16'hAB00, pclk)
        wb(1'b1, 8'h14, 32'hFFFFFFFF);
        wb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        check_all();
        wb(1'b1, ADR_VOLT, 32'h0000000D);
        n = 0;
        while (lvl !== 4'hD && n < 500) begin
            @(posedge clk);
            n++;
        end
        #1;
        `CHK("level step", 4'hD, lvl)
        `CHK("step time", VSTEP_CYC, n)
        wb(1'b0, ADR_STAT, 32'h0);
        `CHK("status level", 4'hD, rd[27:24])
        wb(1'b1, ADR_VOLT, 32'h0);
        s = 3'h4;
        check_all();
        set_mode(5'h01);
        check_all();
        wb(1'b1, ADR_VOLT, 32'h0000000C);
        n = 0;
        while (pwr !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        #1;
        s = 3'h0;
        appl = pend;
        check_all();
        finish_test();
    end
endmodule
`default_nettype wire
